// [conversion_status_pkg.sv]
// Types shared by the conversion status word logic.
// Assumes the cfg header supplies the address width; the 2-bit counter and 16-bit word widths are fixed here.
`include "conversion_status_word_cfg.svh"
package conversion_status_pkg;
    typedef logic [1:0] wrap_count_t;
    typedef logic [15:0] status_word_t;
    typedef logic [`CSW_ADDR_W-1:0] reg_addr_t;
endpackage : conversion_status_pkg

// [conversion_status_word.sv]
// Status word logic: clock/mode bits and the low status word with counters.
// Assumes event strobes and enables come from logic on clk_sys; no synchronisers.
// What this block does
// - The clock bit reads 0 on the internal oscillator and 1 on an external clock.
// - The mode bit reads 0 in active mode and 1 in standby or power-down.
// - Bits 15:14 count completed voltage-ADC sequences, wrapping at four.
// - The sequence counter clears when the voltage ADC is disabled, in standby or on reset.
// - Bits 11:10 count completed conversions of current ADC A, wrapping at four.
// - The ADC A counter clears when that ADC is disabled, in standby or on reset.
// - Bits 9:8 count completed conversions of current ADC B, wrapping at four.
// - The ADC B counter clears when that ADC is disabled, in standby or on reset.
// - Bit 1 follows voltage_sequence_running gated by voltage_adc_enable, two edges late.
`timescale 1ns/1ps
`include "conversion_status_word_cfg.svh"
module conversion_status_word
    import conversion_status_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Device state
    input wire logic ext_clock_in_use,
    input wire logic standby_or_powerdown,
    input wire logic voltage_adc_enable,
    input wire logic current_adc_a_enable,
    input wire logic current_adc_b_enable,
    // Completion events, one-cycle pulses, then the sequence-running level
    input wire logic voltage_sequence_done,
    input wire logic current_adc_a_conv_done,
    input wire logic current_adc_b_conv_done,
    input wire logic voltage_sequence_running,
    // Register read port
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire reg_addr_t reg_addr,
    input wire status_word_t reg_wdata,
    output logic [15:0] reg_rdata_ff,
    // Decoded status outputs
    output logic clock_source_ff,
    output logic mode_standby_ff,
    output logic [15:0] progress_word_ff
);

    function automatic wrap_count_t step_count(input wrap_count_t cur, input logic clr,
                                               input logic ev);
        if (clr) begin
            return 2'h0;
        end else if (ev) begin
            return wrap_count_t'(cur + 2'h1);
        end
        return cur;
    endfunction : step_count

    // Clear wins over a completion landing in the same cycle
    function automatic logic clear_cond(input logic enable, input logic low_power);
        return ~enable | low_power;
    endfunction : clear_cond

    // Counter group
    wrap_count_t seq_cnt_ff;
    wrap_count_t conv_a_cnt_ff;
    wrap_count_t conv_b_cnt_ff;
    wrap_count_t nxt_seq_cnt;
    wrap_count_t nxt_conv_a_cnt;
    wrap_count_t nxt_conv_b_cnt;
    logic running_ff;
    logic nxt_running;
    // Status group
    logic nxt_clock_source;
    logic nxt_mode_standby;
    status_word_t nxt_progress_word;
    // Read group
    status_word_t nxt_reg_rdata;
    logic unused_wr;

    // Writes have no effect on read-only status
    assign unused_wr = reg_wr ^ (|reg_wdata);

    // Completion counters and the running flag
    always_comb begin
        nxt_seq_cnt = step_count(seq_cnt_ff,
                                 clear_cond(voltage_adc_enable, standby_or_powerdown),
                                 voltage_sequence_done);
        nxt_conv_a_cnt = step_count(conv_a_cnt_ff,
                                    clear_cond(current_adc_a_enable, standby_or_powerdown),
                                    current_adc_a_conv_done);
        nxt_conv_b_cnt = step_count(conv_b_cnt_ff,
                                    clear_cond(current_adc_b_enable, standby_or_powerdown),
                                    current_adc_b_conv_done);
        // Disabled ADC cannot be mid-sequence
        nxt_running = voltage_sequence_running & voltage_adc_enable;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            seq_cnt_ff <= 2'h0;
            conv_a_cnt_ff <= 2'h0;
            conv_b_cnt_ff <= 2'h0;
            running_ff <= 1'b0;
        end else begin
            seq_cnt_ff <= nxt_seq_cnt;
            conv_a_cnt_ff <= nxt_conv_a_cnt;
            conv_b_cnt_ff <= nxt_conv_b_cnt;
            running_ff <= nxt_running;
        end
    end

    // Status outputs; the word lags the counters by one edge
    always_comb begin
        nxt_clock_source = ext_clock_in_use;
        nxt_mode_standby = standby_or_powerdown;
        nxt_progress_word = `CSW_PROGRESS_RESET;
        nxt_progress_word[`CSW_BIT_SEQ_HI:`CSW_BIT_SEQ_LO] = seq_cnt_ff;
        nxt_progress_word[`CSW_BIT_CONVA_HI:`CSW_BIT_CONVA_LO] = conv_a_cnt_ff;
        nxt_progress_word[`CSW_BIT_CONVB_HI:`CSW_BIT_CONVB_LO] = conv_b_cnt_ff;
        nxt_progress_word[`CSW_BIT_RUNNING] = running_ff;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            clock_source_ff <= 1'b0;
            mode_standby_ff <= 1'b0;
            progress_word_ff <= `CSW_PROGRESS_RESET;
        end else begin
            clock_source_ff <= nxt_clock_source;
            mode_standby_ff <= nxt_mode_standby;
            progress_word_ff <= nxt_progress_word;
        end
    end

    // Read port; data holds until the next read strobe
    always_comb begin
        nxt_reg_rdata = reg_rdata_ff;
        if (reg_rd) begin
            if (reg_addr == `CSW_OFS_PROGRESS) begin
                nxt_reg_rdata = nxt_progress_word;
            end else if (reg_addr == `CSW_OFS_PRECEDING) begin
                nxt_reg_rdata = 16'h0000;
                nxt_reg_rdata[`CSW_BIT_CLOCK] = clock_source_ff;
                nxt_reg_rdata[`CSW_BIT_MODE] = mode_standby_ff;
            end else begin
                // Other registers live elsewhere
                nxt_reg_rdata = 16'h0000;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata_ff <= 16'h0000;
        end else begin
            reg_rdata_ff <= nxt_reg_rdata;
        end
    end

    chk_seq_counter_step: assert property (@(posedge clk_sys) disable iff (rst)
        voltage_sequence_done && voltage_adc_enable && !standby_or_powerdown
        |=> seq_cnt_ff == 2'($past(seq_cnt_ff) + 2'h1))
        else $error("sequence counter did not advance");
    chk_seq_counter_clear: assert property (@(posedge clk_sys) disable iff (rst)
        (!voltage_adc_enable || standby_or_powerdown) |=> ##1
        progress_word_ff[15:14] == 2'h0)
        else $error("sequence counter not cleared");
    chk_conv_a_step: assert property (@(posedge clk_sys) disable iff (rst)
        current_adc_a_conv_done && current_adc_a_enable && !standby_or_powerdown
        |=> conv_a_cnt_ff == 2'($past(conv_a_cnt_ff) + 2'h1))
        else $error("adc a counter did not advance");
    chk_conv_a_clear: assert property (@(posedge clk_sys) disable iff (rst)
        (!current_adc_a_enable || standby_or_powerdown) |=> conv_a_cnt_ff == 2'h0)
        else $error("adc a counter not cleared");
    chk_conv_b_step: assert property (@(posedge clk_sys) disable iff (rst)
        current_adc_b_conv_done && current_adc_b_enable && !standby_or_powerdown
        |=> conv_b_cnt_ff == 2'($past(conv_b_cnt_ff) + 2'h1))
        else $error("adc b counter did not advance");
    chk_conv_b_clear: assert property (@(posedge clk_sys) disable iff (rst)
        (!current_adc_b_enable || standby_or_powerdown) |=> conv_b_cnt_ff == 2'h0)
        else $error("adc b counter not cleared");
    chk_running_bit: assert property (@(posedge clk_sys) disable iff (rst)
        voltage_sequence_running && voltage_adc_enable |=> ##1 progress_word_ff[1])
        else $error("running bit missing");
    chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (rst)
        progress_word_ff[13:12] == 2'h0 && progress_word_ff[7:2] == 6'h00
        && !progress_word_ff[0])
        else $error("reserved bits not zero");
    chk_clock_mode_bits: assert property (@(posedge clk_sys) disable iff (rst)
        1'b1 |=> clock_source_ff == $past(ext_clock_in_use)
        && mode_standby_ff == $past(standby_or_powerdown))
        else $error("clock or mode bit wrong");
    chk_seq_counter_hold: assert property (@(posedge clk_sys) disable iff (rst)
        !voltage_sequence_done && voltage_adc_enable && !standby_or_powerdown
        |=> $stable(seq_cnt_ff))
        else $error("sequence counter moved without an event");
    chk_running_gate: assert property (@(posedge clk_sys) disable iff (rst)
        !voltage_adc_enable |=> ##1 !progress_word_ff[1])
        else $error("running bit set while adc disabled");
    chk_running_low: assert property (@(posedge clk_sys) disable iff (rst)
        !voltage_sequence_running |=> ##1 !progress_word_ff[1])
        else $error("running bit set with no sequence");
    chk_read_progress: assert property (@(posedge clk_sys) disable iff (rst)
        reg_rd && reg_addr == `CSW_OFS_PROGRESS
        |=> reg_rdata_ff[15:14] == $past(seq_cnt_ff)
        && reg_rdata_ff[11:10] == $past(conv_a_cnt_ff)
        && reg_rdata_ff[9:8] == $past(conv_b_cnt_ff))
        else $error("progress read data wrong");
    chk_read_clock_mode: assert property (@(posedge clk_sys) disable iff (rst)
        reg_rd && reg_addr == `CSW_OFS_PRECEDING
        |=> reg_rdata_ff == {14'h0000, $past(clock_source_ff), $past(mode_standby_ff)})
        else $error("clock and mode read data wrong");
    chk_read_other_zero: assert property (@(posedge clk_sys) disable iff (rst)
        reg_rd && reg_addr != `CSW_OFS_PRECEDING && reg_addr != `CSW_OFS_PROGRESS
        |=> reg_rdata_ff == 16'h0000)
        else $error("unmapped read not zero");
    chk_rdata_hold: assert property (@(posedge clk_sys) disable iff (rst)
        !reg_rd |=> $stable(reg_rdata_ff))
        else $error("read data changed without a read");

    cov_seq_wrap: cover property (@(posedge clk_sys) disable iff (rst)
        seq_cnt_ff == 2'h3 ##1 seq_cnt_ff == 2'h0);
    cov_both_current: cover property (@(posedge clk_sys) disable iff (rst)
        current_adc_a_conv_done && current_adc_b_conv_done);
    cov_progress_read: cover property (@(posedge clk_sys) disable iff (rst)
        reg_rd && reg_addr == `CSW_OFS_PROGRESS && seq_cnt_ff != 2'h0);
    cov_standby_clear: cover property (@(posedge clk_sys) disable iff (rst)
        standby_or_powerdown && conv_a_cnt_ff != 2'h0);
    cov_unmapped_read: cover property (@(posedge clk_sys) disable iff (rst)
        reg_rd && reg_addr != `CSW_OFS_PRECEDING && reg_addr != `CSW_OFS_PROGRESS);

endmodule : conversion_status_word

// [conversion_status_word_cfg.svh]
// Register offsets, field positions and reset values for the conversion status word.
// Assumes inclusion by the package and the design module only.
`ifndef CONVERSION_STATUS_WORD_CFG_SVH
`define CONVERSION_STATUS_WORD_CFG_SVH
`define CSW_ADDR_W 8
`define CSW_OFS_PRECEDING 8'h01
`define CSW_OFS_PROGRESS 8'h02
`define CSW_PROGRESS_RESET 16'h0000
`define CSW_BIT_SEQ_HI 15
`define CSW_BIT_SEQ_LO 14
`define CSW_BIT_CONVA_HI 11
`define CSW_BIT_CONVA_LO 10
`define CSW_BIT_CONVB_HI 9
`define CSW_BIT_CONVB_LO 8
`define CSW_BIT_RUNNING 1
`define CSW_BIT_CLOCK 1
`define CSW_BIT_MODE 0
`define CSW_VADC_CFG_FIRST 8'h8c
`define CSW_VADC_CFG_LAST 8'h9f
`endif

// [conversion_status_word_tb.sv]
// Self-checking bench for conversion_status_word with a host model.
// Assumes events are one-cycle pulses and reads answer one cycle later.
`timescale 1ns/1ps
module conversion_status_word_tb;
    import conversion_status_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ext_clk = 0, stby = 0, v_en = 1, a_en = 1, b_en = 1, v_run = 0;
    logic v_done = 0, a_done = 0, b_done = 0, rd, wr, clk_src, mode_sb;
    reg_addr_t addr;
    status_word_t wdata, rdata, word, q;
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;
    always #5 clk_sys = ~clk_sys;
    conversion_status_word conversion_status_word_inst (.clk_sys(clk_sys), .rst(rst),
        .ext_clock_in_use(ext_clk), .standby_or_powerdown(stby),
        .voltage_adc_enable(v_en), .current_adc_a_enable(a_en),
        .current_adc_b_enable(b_en), .voltage_sequence_done(v_done),
        .current_adc_a_conv_done(a_done), .current_adc_b_conv_done(b_done),
        .voltage_sequence_running(v_run), .reg_rd(rd), .reg_wr(wr), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata_ff(rdata), .clock_source_ff(clk_src),
        .mode_standby_ff(mode_sb), .progress_word_ff(word));
    host_reg_reader host_reg_reader_inst (.clk_sys(clk_sys), .rdata(rdata), .rd(rd),
        .wr(wr), .addr(addr), .wdata(wdata));
    task automatic check(input string what, input status_word_t exp, input status_word_t seen);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            end_sim();
        end
    end
    // Back-to-back pulses, then time for the word to catch up
    task automatic pulses(input int nv, input int na, input int nb);
        for (int i = 0; i < 6; i++) begin
            @(negedge clk_sys);
            {v_done, a_done, b_done} = {i < nv, i < na, i < nb};
        end
        repeat (3) @(negedge clk_sys);
    endtask : pulses
    task automatic rd_chk(input reg_addr_t a, input status_word_t exp);
        host_reg_reader_inst.access(1'b0, a, 16'h0000, q);
        check($sformatf("read %h", a), exp, q);
    endtask : rd_chk
    task automatic test_modes;
        rd_chk(8'h02, 16'h0000);
        rd_chk(8'h05, 16'h0000);
        ext_clk = 1;
        pulses(0, 0, 0);
        check("clock", 16'h0001, {15'h0000, clk_src});
        rd_chk(8'h01, 16'h0002);
        stby = 1;
        pulses(0, 0, 0);
        rd_chk(8'h01, 16'h0003);
        {stby, ext_clk} = 2'b00;
        pulses(0, 0, 0);
        rd_chk(8'h01, 16'h0000);
        $display("test_modes done");
    endtask : test_modes
    task automatic test_counts;
        v_run = 1;
        pulses(5, 3, 2);
        check("word", 16'h4e02, word);
        rd_chk(8'h02, 16'h4e02);
        host_reg_reader_inst.access(1'b1, 8'h02, 16'hffff, q);
        v_run = 0;
        pulses(0, 0, 0);
        rd_chk(8'h02, 16'h4e00);
        $display("test_counts done");
    endtask : test_counts
    task automatic test_clears;
        v_en = 0;
        pulses(2, 0, 0);
        rd_chk(8'h02, 16'h0e00);
        {v_en, a_en} = 2'b10;
        pulses(0, 0, 0);
        rd_chk(8'h02, 16'h0200);
        {a_en, b_en} = 2'b10;
        pulses(1, 1, 0);
        rd_chk(8'h02, 16'h4400);
        b_en = 1;
        pulses(1, 1, 1);
        stby = 1;
        pulses(0, 0, 0);
        rd_chk(8'h02, 16'h0000);
        stby = 0;
        pulses(1, 1, 1);
        rst = 1;
        pulses(0, 0, 0);
        rst = 0;
        rd_chk(8'h02, 16'h0000);
        $display("test_clears done");
    endtask : test_clears
    initial begin
        repeat (5) @(negedge clk_sys);
        rst = 1'b0;
        test_modes();
        test_counts();
        test_clears();
        end_sim();
    end
endmodule : conversion_status_word_tb

// [host_reg_reader.sv]
// Host model: issues register reads and writes on the status register port.
// Assumes clk_sys is the device clock; requests change only at falling edges.
`timescale 1ns/1ps
module host_reg_reader
    import conversion_status_pkg::*;
(
    // Clock and answer
    input wire logic clk_sys,
    input wire status_word_t rdata,
    // Request
    output logic rd,
    output logic wr,
    output reg_addr_t addr,
    output status_word_t wdata
);
    initial {rd, wr, addr, wdata} = '0;
    // Writes go to any address the caller passes; nothing here keeps them out of the voltage-ADC setup range
    task automatic access(input logic w, input reg_addr_t a, input status_word_t d,
                          output status_word_t q);
        @(negedge clk_sys);
        rd = !w;
        wr = w;
        addr = a;
        wdata = d;
        @(negedge clk_sys);
        {rd, wr} = 2'b00;
        // Released lines show the inverse, so stale values cannot pass
        addr = ~a;
        wdata = ~d;
        q = rdata;
    endtask : access
endmodule : host_reg_reader
